// file: psvt_pkg.sv
// psvt_pkg: message codes, status values, event codes and timing for the
// segment verify / terminate engine. Assumes a single 100 MHz system clock.
package psvt_pkg;
	// exchange bus message kinds (destination handler in the peer)
	localparam logic [2:0] PSVT_MSG_DMA_PARAM   = 3'h0; // dma control word to peer
	localparam logic [2:0] PSVT_MSG_DATA        = 3'h1; // one segment data word
	localparam logic [2:0] PSVT_MSG_VERIFY      = 3'h2; // check word to verification handler
	localparam logic [2:0] PSVT_MSG_SEG_TERM    = 3'h3; // check word nak to active port
	localparam logic [2:0] PSVT_MSG_SEG_DONE    = 3'h4; // segment completion status
	localparam logic [2:0] PSVT_MSG_DMA_WRITE   = 3'h5; // segment length to passive writer
	localparam logic [2:0] PSVT_MSG_SEG_NOTIFY  = 3'h6; // good segment to passive port
	localparam logic [2:0] PSVT_MSG_TERM        = 3'h7; // termination request / echo
	// status values
	localparam logic [15:0] PSVT_STAT_ACK       = 16'h0001;
	localparam logic [15:0] PSVT_STAT_NAK       = 16'h0002;
	localparam logic [15:0] PSVT_STAT_CHK_NAK   = 16'h0003;
	// interrupt event codes to the port processor
	localparam logic [2:0] PSVT_EV_SEG_GOOD     = 3'h1;
	localparam logic [2:0] PSVT_EV_SEG_STATUS   = 3'h2;
	localparam logic [2:0] PSVT_EV_CHECK_ERR    = 3'h3;
	localparam logic [2:0] PSVT_EV_TERM         = 3'h4;
	localparam logic [2:0] PSVT_EV_DIALOG_END   = 3'h5;
	localparam logic [2:0] PSVT_EV_OUT_OF_SYNC  = 3'h6;
	// dma control word: bit 15 set means passive to active
	localparam int          PSVT_DCW_DIR_BIT    = 15;
	localparam int          PSVT_DCW_LEN_W      = 15;
	// check word reset value
	localparam logic [15:0] PSVT_CHK_INIT       = 16'h0000;
	// time-out
	localparam int          PSVT_CLK_MHZ        = 100;
	localparam int          PSVT_TIMEOUT_US     = 1000;
	localparam int          PSVT_TIMEOUT_CYC    = PSVT_TIMEOUT_US * PSVT_CLK_MHZ;
	// engine states
	typedef enum logic [3:0] {
		PSVT_IDLE      = 4'b0000,
		PSVT_A_SEND    = 4'b0001,
		PSVT_A_RECV    = 4'b0011,
		PSVT_A_WAIT    = 4'b0010,
		PSVT_P_SEND    = 4'b0110,
		PSVT_P_RECV    = 4'b0111,
		PSVT_P_WAIT    = 4'b0101,
		PSVT_P_AVAIL   = 4'b0100
	} psvt_state_e;
endpackage : psvt_pkg

// file: psvt_timer.sv
// psvt_timer: reloadable time-out counter, one-cycle expiry pulse.
// Assumes start and stop come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module psvt_timer
	import psvt_pkg::*;
#(
	parameter int TIMEOUT_CYC = PSVT_TIMEOUT_CYC
)(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic start,
	input  wire logic stop,
	output logic      expired
);
	localparam int CW = $clog2(TIMEOUT_CYC + 1);
	// a reload needs at least two cycles to count down and pulse
	if (TIMEOUT_CYC < 2)
	begin : g_bad_timeout
		$error("psvt_timer: TIMEOUT_CYC too small");
	end

	logic [CW-1:0] count_reg;
	logic          run_reg;

	// reload on start, stop cancels, expiry pulses once
	always_ff @(posedge clk_sys)
	begin
		expired <= 1'b0;
		if (rst)
		begin
			count_reg <= '0;
			run_reg   <= 1'b0;
		end
		else if (start)
		begin
			count_reg <= CW'(TIMEOUT_CYC - 1);
			run_reg   <= 1'b1;
		end
		else if (stop)
			run_reg <= 1'b0;
		else if (run_reg)
		begin
			if (count_reg == '0)
			begin
				run_reg <= 1'b0;
				expired <= 1'b1;
			end
			else
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule : psvt_timer
`default_nettype wire

// file: psvt_engine.sv
// psvt_engine: segment transfer, check word verification and dialogue
// termination for one port, both active and passive roles.
// Assumes the peer and the exchange bus accept one message per cycle when
// tx_ready is high, and that port memory answers mem_rd with mem_rdata
// in the same cycle that mem_rd is high.
`timescale 1ns/1ps
`default_nettype none
module psvt_engine
	import psvt_pkg::*;
#(
	parameter int TIMEOUT_CYC = PSVT_TIMEOUT_CYC
)(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// port processor commands
	input  wire logic        cmd_seg_start,
	input  wire logic [15:0] cmd_dcw,
	input  wire logic        cmd_seg_status,
	input  wire logic        cmd_seg_ok,
	input  wire logic        cmd_term,
	input  wire logic [15:0] table_term_status,
	// exchange bus receive
	input  wire logic        rx_valid,
	input  wire logic [2:0]  rx_kind,
	input  wire logic [15:0] rx_data,
	// exchange bus transmit
	input  wire logic        tx_ready,
	output logic             tx_valid,
	output logic [2:0]       tx_kind,
	output logic [15:0]      tx_data,
	// port memory
	output logic             mem_rd,
	output logic             mem_wr,
	output logic [15:0]      mem_addr,
	output logic [15:0]      mem_wdata,
	input  wire logic [15:0] mem_rdata,
	// port processor interrupt and status
	output logic             irq,
	output logic [2:0]       irq_event,
	output logic [15:0]      irq_status,
	output logic [15:0]      term_status_store,
	output logic             passive_avail
);
	psvt_state_e   state_reg;
	logic [15:0]   chk_reg;
	logic [14:0]   len_reg;
	logic [14:0]   cnt_reg;
	logic          dir_p2a_reg;
	logic          rd_pend_reg;
	logic          tmr_start;
	logic          tmr_stop;
	logic          tmr_expired;

	// single-message send helper used on every outgoing path
	function automatic logic tx_free(input logic v, input logic rdy);
		return !v || rdy;
	endfunction

	psvt_timer #(
		.TIMEOUT_CYC (TIMEOUT_CYC)
	) u_timer (
		.clk_sys (clk_sys),
		.rst     (rst),
		.start   (tmr_start),
		.stop    (tmr_stop),
		.expired (tmr_expired)
	);

	// main dialogue sequencer
	always_ff @(posedge clk_sys)
	begin
		tmr_start <= 1'b0;
		tmr_stop  <= 1'b0;
		irq       <= 1'b0;
		mem_rd    <= 1'b0;
		mem_wr    <= 1'b0;
		if (rst)
		begin
			state_reg         <= PSVT_IDLE;
			chk_reg           <= PSVT_CHK_INIT;
			len_reg           <= '0;
			cnt_reg           <= '0;
			dir_p2a_reg       <= 1'b0;
			rd_pend_reg       <= 1'b0;
			tx_valid          <= 1'b0;
			tx_kind           <= '0;
			tx_data           <= '0;
			mem_addr          <= '0;
			mem_wdata         <= '0;
			irq_event         <= '0;
			irq_status        <= '0;
			term_status_store <= '0;
			passive_avail     <= 1'b1;
		end
		else
		begin
			// a message leaves once the peer takes it
			if (tx_valid && tx_ready)
				tx_valid <= 1'b0;
			if (tmr_expired)
			begin
				irq        <= 1'b1;
				irq_event  <= PSVT_EV_OUT_OF_SYNC;
				irq_status <= '0;
				state_reg  <= PSVT_IDLE;
				passive_avail <= 1'b1;
			end
			else if (cmd_seg_start && tx_free(tx_valid, tx_ready))
			begin
				// active side opens a segment
				tmr_stop    <= 1'b1;
				chk_reg     <= PSVT_CHK_INIT;
				len_reg     <= cmd_dcw[PSVT_DCW_LEN_W-1:0];
				cnt_reg     <= '0;
				mem_addr    <= '0;
				dir_p2a_reg <= cmd_dcw[PSVT_DCW_DIR_BIT];
				tx_valid    <= 1'b1;
				if (cmd_dcw[PSVT_DCW_DIR_BIT])
				begin
					tx_kind   <= PSVT_MSG_DMA_WRITE;
					tx_data   <= {1'b0, cmd_dcw[PSVT_DCW_LEN_W-1:0]};
					tmr_start <= 1'b1;
					state_reg <= PSVT_A_RECV;
				end
				else
				begin
					tx_kind   <= PSVT_MSG_DMA_PARAM;
					tx_data   <= cmd_dcw;
					state_reg <= PSVT_A_SEND;
				end
			end
			else if (cmd_seg_status && tx_free(tx_valid, tx_ready))
			begin
				tx_valid  <= 1'b1;
				tx_kind   <= PSVT_MSG_SEG_DONE;
				tx_data   <= cmd_seg_ok ? PSVT_STAT_ACK : PSVT_STAT_NAK;
				tmr_start <= 1'b1;
				state_reg <= PSVT_P_WAIT;
			end
			else if (cmd_term && tx_free(tx_valid, tx_ready))
			begin
				tx_valid  <= 1'b1;
				tx_kind   <= PSVT_MSG_TERM;
				tx_data   <= (table_term_status == PSVT_STAT_ACK) ? PSVT_STAT_ACK
				                                                : PSVT_STAT_NAK;
				tmr_start <= 1'b1;
				state_reg <= PSVT_A_WAIT;
			end
			else
			begin
				unique case (state_reg)
					PSVT_A_SEND, PSVT_P_SEND:
					begin
						// source side: read memory and stream words
						if (rd_pend_reg && tx_free(tx_valid, tx_ready))
						begin
							rd_pend_reg <= 1'b0;
							tx_valid    <= 1'b1;
							tx_kind     <= PSVT_MSG_DATA;
							tx_data     <= mem_rdata;
							chk_reg     <= chk_reg + mem_rdata;
							cnt_reg     <= cnt_reg + 15'd1;
							mem_addr    <= mem_addr + 16'd1;
						end
						else if (!rd_pend_reg && cnt_reg != len_reg && !tx_valid)
						begin
							mem_rd      <= 1'b1;
							rd_pend_reg <= 1'b1;
						end
						else if (!rd_pend_reg && cnt_reg == len_reg
						         && tx_free(tx_valid, tx_ready))
						begin
							tx_valid  <= 1'b1;
							tx_kind   <= PSVT_MSG_VERIFY;
							tx_data   <= chk_reg;
							tmr_start <= 1'b1;
							state_reg <= (state_reg == PSVT_A_SEND) ? PSVT_A_WAIT
							                                        : PSVT_P_WAIT;
						end
					end
					PSVT_A_RECV, PSVT_P_RECV:
					begin
						// sink side: store words and check the sum
						if (rx_valid && rx_kind == PSVT_MSG_DATA)
						begin
							mem_wr    <= 1'b1;
							mem_wdata <= rx_data;
							mem_addr  <= cnt_reg == '0 ? 16'h0000 : mem_addr + 16'd1;
							chk_reg   <= chk_reg + rx_data;
							cnt_reg   <= cnt_reg + 15'd1;
							tmr_start <= 1'b1;
						end
						else if (rx_valid && rx_kind == PSVT_MSG_VERIFY
						         && tx_free(tx_valid, tx_ready))
						begin
							tmr_start <= 1'b1;
							if (state_reg == PSVT_P_RECV)
							begin
								state_reg <= PSVT_P_WAIT;
								if (rx_data != chk_reg)
								begin
									tx_valid <= 1'b1;
									tx_kind  <= PSVT_MSG_SEG_TERM;
									tx_data  <= PSVT_STAT_CHK_NAK;
								end
								else
								begin
									irq        <= 1'b1;
									irq_event  <= PSVT_EV_SEG_GOOD;
									irq_status <= PSVT_STAT_ACK;
								end
							end
							else
							begin
								state_reg <= PSVT_A_WAIT;
								if (rx_data == chk_reg)
								begin
									tx_valid <= 1'b1;
									tx_kind  <= PSVT_MSG_SEG_NOTIFY;
									tx_data  <= PSVT_STAT_ACK;
								end
								else
								begin
									irq        <= 1'b1;
									irq_event  <= PSVT_EV_CHECK_ERR;
									irq_status <= PSVT_STAT_CHK_NAK;
								end
							end
						end
					end
					PSVT_A_WAIT:
					begin
						// active waits for segment status or termination echo
						// a check nak only answers an active write
						if (rx_valid && (rx_kind == PSVT_MSG_SEG_DONE
						                 || (rx_kind == PSVT_MSG_SEG_TERM
						                     && !dir_p2a_reg)))
						begin
							irq        <= 1'b1;
							irq_event  <= PSVT_EV_SEG_STATUS;
							irq_status <= rx_data;
							tmr_start  <= 1'b1;
							state_reg  <= PSVT_IDLE;
						end
						else if (rx_valid && rx_kind == PSVT_MSG_TERM)
						begin
							irq        <= 1'b1;
							irq_event  <= PSVT_EV_DIALOG_END;
							irq_status <= rx_data;
							tmr_stop   <= 1'b1;
							state_reg  <= PSVT_IDLE;
						end
					end
					PSVT_P_AVAIL:
					begin
						// echo sent: passive role free again
						if (tx_free(tx_valid, tx_ready))
						begin
							passive_avail <= 1'b1;
							state_reg     <= PSVT_IDLE;
						end
					end
					PSVT_IDLE, PSVT_P_WAIT:
					begin
						// idle and passive wait: react to peer messages
						if (rx_valid && rx_kind == PSVT_MSG_DMA_PARAM)
						begin
							passive_avail <= 1'b0;
							chk_reg       <= PSVT_CHK_INIT;
							cnt_reg       <= '0;
							len_reg       <= rx_data[PSVT_DCW_LEN_W-1:0];
							tmr_start     <= 1'b1;
							state_reg     <= PSVT_P_RECV;
						end
						else if (rx_valid && rx_kind == PSVT_MSG_DMA_WRITE)
						begin
							passive_avail <= 1'b0;
							chk_reg       <= PSVT_CHK_INIT;
							cnt_reg       <= '0;
							mem_addr      <= '0;
							len_reg       <= rx_data[PSVT_DCW_LEN_W-1:0];
							tmr_stop      <= 1'b1;
							state_reg     <= PSVT_P_SEND;
						end
						else if (rx_valid && rx_kind == PSVT_MSG_SEG_NOTIFY)
						begin
							irq        <= 1'b1;
							irq_event  <= PSVT_EV_SEG_GOOD;
							irq_status <= rx_data;
							tmr_start  <= 1'b1;
							state_reg  <= PSVT_P_WAIT;
						end
						else if (rx_valid && rx_kind == PSVT_MSG_TERM
						         && tx_free(tx_valid, tx_ready))
						begin
							term_status_store <= rx_data;
							irq        <= 1'b1;
							irq_event  <= PSVT_EV_TERM;
							irq_status <= rx_data;
							tx_valid   <= 1'b1;
							tx_kind    <= PSVT_MSG_TERM;
							tx_data    <= rx_data;
							tmr_stop   <= 1'b1;
							state_reg  <= PSVT_P_AVAIL;
						end
					end
					default:
					begin
						// unused state code: fall back to idle
						state_reg <= PSVT_IDLE;
					end
				endcase
			end
		end
	end

	// the timer cannot serve a time-out shorter than two cycles
	if (TIMEOUT_CYC < 2)
	begin : g_bad_timeout
		$error("psvt_engine: TIMEOUT_CYC too small");
	end
endmodule : psvt_engine
`default_nettype wire

// file: psvt_engine_monitor.sv
// psvt_engine_monitor: port assertions for psvt_engine, bound below.
// Assumes one clk_sys domain with a synchronous active high rst.
`timescale 1ns/1ps
`default_nettype none
module psvt_engine_monitor
	import psvt_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        cmd_seg_start,
	input  wire logic [15:0] cmd_dcw,
	input  wire logic        cmd_seg_status,
	input  wire logic        cmd_seg_ok,
	input  wire logic        cmd_term,
	input  wire logic [15:0] table_term_status,
	input  wire logic        tx_ready,
	input  wire logic        tx_valid,
	input  wire logic [2:0]  tx_kind,
	input  wire logic [15:0] tx_data,
	input  wire logic        irq,
	input  wire logic [2:0]  irq_event,
	input  wire logic [15:0] term_status_store,
	input  wire logic        passive_avail
);
	logic idle_cmd;
	// nothing pending and no segment start competing
	assign idle_cmd = !tx_valid && !cmd_seg_start;
	default clocking mcb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// passive termination: interrupt, and echo of the stored status within three cycles
	sequence s_term_irq;
		irq && irq_event == PSVT_EV_TERM;
	endsequence
	sequence s_echo;
		tx_valid && tx_kind == PSVT_MSG_TERM && tx_data == term_status_store;
	endsequence
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("message not held");
	active_wr_a: assert property (cmd_seg_start && !tx_valid && !cmd_dcw[15]
		|=> tx_valid && tx_kind == PSVT_MSG_DMA_PARAM) else $error("no dma parameter");
	passive_wr_a: assert property (cmd_seg_start && !tx_valid && cmd_dcw[15]
		|=> tx_valid && tx_kind == PSVT_MSG_DMA_WRITE) else $error("no segment length");
	seg_status_a: assert property (cmd_seg_status && idle_cmd |=> tx_valid
		&& tx_kind == PSVT_MSG_SEG_DONE
		&& tx_data == ($past(cmd_seg_ok) ? PSVT_STAT_ACK : PSVT_STAT_NAK))
		else $error("wrong segment status");
	term_req_a: assert property (cmd_term && idle_cmd && !cmd_seg_status |=> tx_valid
		&& tx_kind == PSVT_MSG_TERM && tx_data == ($past(table_term_status)
		== PSVT_STAT_ACK ? PSVT_STAT_ACK : PSVT_STAT_NAK)) else $error("wrong termination");
	nak_quiet_a: assert property (tx_valid && tx_kind == PSVT_MSG_SEG_TERM
		|-> !irq && tx_data == PSVT_STAT_CHK_NAK) else $error("check nak wrong");
	term_echo_a: assert property (s_term_irq |-> ##[0:3] s_echo)
		else $error("status not echoed");
	sync_idle_a: assert property (irq && irq_event == PSVT_EV_OUT_OF_SYNC
		|-> passive_avail && !tx_valid) else $error("time-out left engine busy");
endmodule : psvt_engine_monitor
bind psvt_engine psvt_engine_monitor u_mon (
	.clk_sys(clk_sys), .rst(rst), .cmd_seg_start(cmd_seg_start), .cmd_dcw(cmd_dcw),
	.cmd_seg_status(cmd_seg_status), .cmd_seg_ok(cmd_seg_ok), .cmd_term(cmd_term),
	.table_term_status(table_term_status), .tx_ready(tx_ready), .tx_valid(tx_valid),
	.tx_kind(tx_kind), .tx_data(tx_data), .irq(irq), .irq_event(irq_event),
	.term_status_store(term_status_store), .passive_avail(passive_avail)
);
`default_nettype wire

// file: psvt_peer_model.sv
// psvt_peer_model: far side of the engine; takes messages, stalling on
// request, and answers port memory reads with a known word sequence.
// Assumes the engine's clk_sys and rst.
`timescale 1ns/1ps
`default_nettype none
module psvt_peer_model
	import psvt_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        stall,
	input  wire logic        mem_rd,
	output logic             tx_ready,
	output logic [15:0]      mem_rdata
);
	logic [15:0] count_reg;
	logic        hold_reg;
	logic        phase_reg;
	// read count, answer window, and a phase that flips every cycle
	always_ff @(posedge clk_sys)
	begin
		phase_reg <= rst ? 1'b0 : ~phase_reg;
		hold_reg <= !rst && mem_rd;
		count_reg <= rst ? 16'h0000 : count_reg + {15'h0000, mem_rd};
	end
	// accept every other cycle while stalling
	assign tx_ready = !stall || phase_reg;
	// word n is C000+n in the read cycle and the next; junk otherwise
	assign mem_rdata = mem_rd ? 16'hC000 + count_reg : hold_reg ? 16'hBFFF + count_reg :
		{16{phase_reg}} ^ (16'h3FFF - count_reg);
endmodule : psvt_peer_model
`default_nettype wire

// file: tb.sv
// tb: self-checking bench for psvt_engine beside the peer model.
// Assumes a 100 MHz clk_sys; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb
	import psvt_pkg::*;
;
	logic        clk_sys = 1'b0, rst = 1'b1, stall = 1'b0, rx_valid = 1'b0;
	logic        cmd_seg_start = 1'b0, cmd_seg_status = 1'b0, cmd_seg_ok = 1'b1, cmd_term = 1'b0;
	logic        tx_ready, tx_valid, mem_rd, mem_wr, irq, passive_avail;
	logic [2:0]  rx_kind = 3'h0, tx_kind, irq_event, ev_seen;
	logic [15:0] cmd_dcw = 16'h0000, table_term_status = 16'h0000, rx_data = 16'h0000;
	logic [15:0] tx_data, mem_addr, mem_wdata, mem_rdata, irq_status, term_status_store;
	logic [15:0] st_seen, wr_seen, ad_seen;
	int          fails = 0, check_count = 0, irq_cnt = 0, cycles = 0;
	always #5 clk_sys = ~clk_sys;
	psvt_engine #(.TIMEOUT_CYC(20)) dut (.clk_sys(clk_sys), .rst(rst),
		.cmd_seg_start(cmd_seg_start), .cmd_dcw(cmd_dcw), .cmd_seg_status(cmd_seg_status),
		.cmd_seg_ok(cmd_seg_ok), .cmd_term(cmd_term), .table_term_status(table_term_status),
		.rx_valid(rx_valid), .rx_kind(rx_kind), .rx_data(rx_data), .tx_ready(tx_ready),
		.tx_valid(tx_valid), .tx_kind(tx_kind), .tx_data(tx_data), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.irq(irq), .irq_event(irq_event), .irq_status(irq_status),
		.term_status_store(term_status_store), .passive_avail(passive_avail));
	psvt_peer_model peer (.clk_sys(clk_sys), .rst(rst), .stall(stall), .mem_rd(mem_rd),
		.tx_ready(tx_ready), .mem_rdata(mem_rdata));
	// record interrupts and memory writes; cut a hang short
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (irq === 1'b1)
		begin
			irq_cnt <= irq_cnt + 1;
			ev_seen <= irq_event;
			st_seen <= irq_status;
		end
		if (mem_wr === 1'b1)
		begin
			wr_seen <= mem_wdata;
			ad_seen <= mem_addr;
		end
		if (cycles == 6000)
		begin
			fails++;
			report_and_stop();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop;
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	// one-cycle command or message; sel is {start, status, term, rx}
	task automatic put(input logic [3:0] sel, input logic [2:0] kind, input logic [15:0] d);
		@(negedge clk_sys);
		{cmd_seg_start, cmd_seg_status, cmd_term, rx_valid} = sel;
		rx_kind = kind;
		rx_data = d;
		cmd_dcw = d;
		table_term_status = d;
		@(negedge clk_sys);
		{cmd_seg_start, cmd_seg_status, cmd_term, rx_valid} = 4'h0;
	endtask : put
	task automatic get_tx(input logic [2:0] kind, input logic [15:0] d);
		int n;
		for (n = 0; n < 40 && !(tx_valid === 1'b1 && tx_ready === 1'b1); n++)
			@(negedge clk_sys);
		check({14'h0000, tx_valid, tx_ready}, 16'h0003);
		check({13'h0000, tx_kind}, {13'h0000, kind});
		check(tx_data, d);
		@(negedge clk_sys);
	endtask : get_tx
	task automatic get_irq(input logic [2:0] ev);
		int n;
		for (n = 0; n < 40 && irq_cnt == 0; n++)
			@(negedge clk_sys);
		check({13'h0000, ev_seen}, {13'h0000, ev});
		irq_cnt = 0;
		ev_seen = 3'h0;
	endtask : get_irq
	task automatic restart;
		@(negedge clk_sys);
		rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		irq_cnt = 0;
		ev_seen = 3'h0;
		wr_seen = 16'h0000;
		ad_seen = 16'hFFFF;
	endtask : restart
	// active write of two words against a stalling peer
	task automatic t_active_write;
		restart();
		stall = 1'b1;
		put(4'h8, 3'h0, 16'h0002);
		get_tx(PSVT_MSG_DMA_PARAM, 16'h0002);
		get_tx(PSVT_MSG_DATA, 16'hC000);
		get_tx(PSVT_MSG_DATA, 16'hC001);
		get_tx(PSVT_MSG_VERIFY, 16'h8001);
		put(4'h1, PSVT_MSG_SEG_DONE, PSVT_STAT_NAK);
		get_irq(PSVT_EV_SEG_STATUS);
		check(st_seen, PSVT_STAT_NAK);
		get_irq(PSVT_EV_OUT_OF_SYNC);
		stall = 1'b0;
	endtask : t_active_write
	// passive side of an active write, check word good or bad
	task automatic t_passive_verify(input logic good);
		restart();
		put(4'h1, PSVT_MSG_DMA_PARAM, 16'h0001);
		put(4'h1, PSVT_MSG_DATA, 16'h1234);
		put(4'h1, PSVT_MSG_VERIFY, good ? 16'h1234 : 16'h1235);
		check(wr_seen, 16'h1234);
		check(ad_seen, 16'h0000);
		if (good)
		begin
			get_irq(PSVT_EV_SEG_GOOD);
			put(4'h4, 3'h0, 16'h0000);
			get_tx(PSVT_MSG_SEG_DONE, PSVT_STAT_ACK);
		end
		else
		begin
			get_tx(PSVT_MSG_SEG_TERM, PSVT_STAT_CHK_NAK);
			check(16'(irq_cnt), 16'h0000);
		end
		get_irq(PSVT_EV_OUT_OF_SYNC);
	endtask : t_passive_verify
	// active side of a passive write, check word good or bad
	task automatic t_active_read(input logic good);
		restart();
		put(4'h8, 3'h0, 16'h8001);
		get_tx(PSVT_MSG_DMA_WRITE, 16'h0001);
		put(4'h1, PSVT_MSG_DATA, 16'h00F0);
		put(4'h1, PSVT_MSG_VERIFY, good ? 16'h00F0 : 16'h00F1);
		check(wr_seen, 16'h00F0);
		if (good)
			get_tx(PSVT_MSG_SEG_NOTIFY, PSVT_STAT_ACK);
		else
			get_irq(PSVT_EV_CHECK_ERR);
		get_irq(PSVT_EV_OUT_OF_SYNC);
	endtask : t_active_read
	// passive side of a passive write of two words
	task automatic t_passive_send;
		restart();
		put(4'h1, PSVT_MSG_DMA_WRITE, 16'h0002);
		get_tx(PSVT_MSG_DATA, 16'hC000);
		get_tx(PSVT_MSG_DATA, 16'hC001);
		get_tx(PSVT_MSG_VERIFY, 16'h8001);
		put(4'h1, PSVT_MSG_SEG_NOTIFY, PSVT_STAT_ACK);
		get_irq(PSVT_EV_SEG_GOOD);
		cmd_seg_ok = 1'b0;
		put(4'h4, 3'h0, 16'h0000);
		get_tx(PSVT_MSG_SEG_DONE, PSVT_STAT_NAK);
		cmd_seg_ok = 1'b1;
	endtask : t_passive_send
	// active termination; no time-out may follow the echo
	task automatic t_term_active(input logic [15:0] st, input logic [15:0] sent);
		restart();
		put(4'h2, 3'h0, st);
		get_tx(PSVT_MSG_TERM, sent);
		put(4'h1, PSVT_MSG_TERM, sent);
		get_irq(PSVT_EV_DIALOG_END);
		repeat (40) @(negedge clk_sys);
		check(16'(irq_cnt), 16'h0000);
	endtask : t_term_active
	// passive termination: store, interrupt, echo, available again
	task automatic t_term_passive;
		restart();
		put(4'h1, PSVT_MSG_DMA_PARAM, 16'h0000);
		check({15'h0000, passive_avail}, 16'h0000);
		put(4'h1, PSVT_MSG_VERIFY, 16'h0000);
		get_irq(PSVT_EV_SEG_GOOD);
		put(4'h1, PSVT_MSG_TERM, PSVT_STAT_NAK);
		get_tx(PSVT_MSG_TERM, PSVT_STAT_NAK);
		get_irq(PSVT_EV_TERM);
		check(term_status_store, PSVT_STAT_NAK);
		check({15'h0000, passive_avail}, 16'h0001);
	endtask : t_term_passive
	// main sequence
	initial
	begin
		repeat (16) @(negedge clk_sys);
		rst = 1'b0;
		t_active_write();
		t_passive_verify(1'b1);
		t_passive_verify(1'b0);
		t_active_read(1'b1);
		t_active_read(1'b0);
		t_passive_send();
		t_term_active(PSVT_STAT_ACK, PSVT_STAT_ACK);
		t_term_active(16'h0005, PSVT_STAT_NAK);
		t_term_passive();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
